// ---- ctsm_frame_mem.sv ----
/*
  Small frame buffer: one write port, one read port with registered data.
  Assumes the writer never addresses beyond DEPTH-1.
*/
`timescale 1ns/10ps
`default_nettype none
module ctsm_frame_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 67,
  parameter int AW = 7
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Array has no reset; only the read register is cleared
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  // Registered read, out-of-range address reads zero
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_rdata <= '0;
    end
    else
    begin
      o_rdata <= (int'(i_raddr) < DEPTH) ? mem_q[i_raddr] : '0;
    end
  end

endmodule
`default_nettype wire

// ---- ctsm_pkg.sv ----
/*
  Shared constants, carrier structs, enumerations and decode helpers for the
  contactless tag protocol state machine.
  Assumes one clock domain. The receive front end delivers whole bytes with
  their parity bit, and an external responder supplies the reply bytes.
*/
// Notes on behaviour
// - Every frame, in either direction, opens with one start bit.
// - Every byte is followed by an odd parity bit.
// - Each byte is serialised least significant bit first, lowest byte first.
// - Reader frames of up to 604 bits are accepted.
// - Reply frames never exceed 595 bits.
// - Range read reply length follows its start and end address arguments.
// - Multi-byte values and read data travel least significant byte first.
// - After reset the tag idles and leaves idle only on REQA or WUPA.
// - A good HLTA from active or authenticated makes halt the wait state.
// - Ready1 resolves UID bytes 0 to 2; CL1 select moves to ready2.
// - In either ready state READ of block 0 goes straight to tag active.
// - Unexpected data in a ready state falls back to the wait state.
// - Ready2 resolves UID bytes 3 to 6; CL2 select completes selection.
// - The CL2 select reply is the SAK, marking the cascade finished.
// - Tag active: HLTA halts, anything unknown falls back to the wait state.
// - A good tag password check in tag active gives tag authenticated.
// - Data memory work from tag active enters the data memory states; unknown data there halts.
// - A good data memory password check gives data memory authenticated.
// - Tag authenticated opens protected blocks; HLTA halts, unknown falls back.
// - Lock page writes are allowed only in data memory authenticated.
// - Halt is left only on WUPA; other data leaves it unchanged.
// - Each reply depends on protocol state and the addressed page's access.
// - A locked 64 byte region refuses data memory read or write with NAK.
`default_nettype none
package ctsm_pkg;

  // ----------------------------------------------------------------
  // Frame sizes and bit budgets
  // ----------------------------------------------------------------
  localparam int RX_MAX_BITS = 604;
  localparam int TX_MAX_BITS = 595;
  localparam int START_BITS = 1;
  localparam int BYTE_BITS = 9;
  localparam int SHORT_BITS = 7;
  localparam int NIB_BITS = 4;
  localparam int RX_MAX_BYTES = 67;
  localparam int BUF_AW = 7;
  localparam int BIT_CW = 10;
  localparam int LEFT_W = 4;
  localparam int HDR_BYTES = 6;
  localparam int ANTICOL_BYTES = 2;
  localparam int SELECT_BYTES = 9;
  localparam int UID_BYTES = 7;
  localparam int CL1_UID_BYTES = 3;
  localparam int HDR_UID_POS = 2;
  localparam int HDR_ARG2_POS = 2;
  localparam logic START_LEVEL = 1'b1;
  localparam logic [LEFT_W-1:0] ONE_LEFT = 4'h1;

  // ----------------------------------------------------------------
  // Fixed frame codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_REQA = 8'h26;
  localparam logic [7:0] CMD_WUPA = 8'h52;
  localparam logic [7:0] CMD_CL1 = 8'h93;
  localparam logic [7:0] CMD_CL2 = 8'h95;
  localparam logic [7:0] NVB_ANTICOL = 8'h20;
  localparam logic [7:0] NVB_SELECT = 8'h70;
  localparam logic [7:0] CASCADE_TAG = 8'h88;
  localparam logic [7:0] BLOCK_ZERO = 8'h00;
  localparam logic [7:0] HLTA_ARG = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_READY1, ST_READY2, ST_TAG_ACT, ST_TAG_AUTH, ST_DM_ACT, ST_DM_AUTH, ST_HALT
  } ctsm_state_t;

  typedef enum logic [4:0] {
    K_ATQA, K_UID_CL1, K_SAK_CL1, K_UID_CL2, K_SAK_CL2, K_TAG_READ, K_TAG_FAST, K_TAG_WRITE,
    K_TAG_PACK, K_DM_READ, K_DM_WRITE, K_DM_ACK, K_LOCK_GET, K_LOCK_SET, K_PWD_TAG, K_PWD_DM, K_NAK
  } ctsm_kind_t;

  typedef struct packed {
    logic sof;
    logic vld;
    logic short_frame;
    logic [7:0] data;
    logic par;
    logic eof;
    logic crc_ok;
  } ctsm_rx_t;

  typedef struct packed {
    logic vld;
    logic nib;
    logic last;
    logic [7:0] data;
  } ctsm_tx_t;

  typedef struct packed {
    logic done;
    logic ok;
  } ctsm_pwd_t;

  typedef struct packed {
    logic req;
    ctsm_kind_t kind;
    logic [7:0] arg;
    logic [7:0] arg2;
  } ctsm_resp_t;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Odd parity: byte plus parity holds an odd number of ones
  function automatic logic odd_par(input logic [7:0] data);
    return ~^data;
  endfunction

  // Select payload against the UID part of the given cascade level
  function automatic logic uid_match(input logic [HDR_BYTES-1:0][7:0] h,
                                     input logic [8*UID_BYTES-1:0] uid, input logic cl2);
    logic m;
    m = cl2 ? (h[HDR_UID_POS] == uid[8*CL1_UID_BYTES +: 8]) : (h[HDR_UID_POS] == CASCADE_TAG);
    for (int i = 0; i < CL1_UID_BYTES; i++)
    begin
      m = m && (h[HDR_UID_POS+1+i] == (cl2 ? uid[8*(CL1_UID_BYTES+1+i) +: 8] : uid[8*i +: 8]));
    end
    return m;
  endfunction

endpackage
`default_nettype wire

// ---- ctsm_reader.sv ----
/*
  Reader model: sends reader-to-tag frames as start, byte and end strobes.
  Assumes the tag samples on rising edges; this model drives on falling ones.
*/
`timescale 1ns/10ps
`default_nettype none
module ctsm_reader (
  input wire logic i_clk,
  output var ctsm_pkg::ctsm_rx_t o_rx
);
  import ctsm_pkg::*;
  initial o_rx = '0;
  // One frame; gap idles before each byte, with the byte lane inverted meanwhile
  // Each strobe is built aside and driven once per edge, so no glitch reaches the lane
  task automatic send(input logic [7:0] b[$], input logic sh, input int gap);
    ctsm_rx_t r;
    r = '0;
    r.sof = 1'b1;
    @(negedge i_clk);
    o_rx = r;
    foreach (b[i])
    begin
      r = '0;
      r.data = ~b[i];
      for (int g = 0; g < gap; g++)
      begin
        @(negedge i_clk);
        o_rx = r;
      end
      r.vld = 1'b1;
      r.short_frame = sh;
      r.data = b[i];
      r.par = ~^b[i];
      @(negedge i_clk);
      o_rx = r;
    end
    r.vld = 1'b0;
    r.data = ~r.data;
    r.eof = 1'b1;
    r.crc_ok = 1'b1;
    @(negedge i_clk);
    o_rx = r;
    @(negedge i_clk);
    o_rx = '0;
  endtask
endmodule
`default_nettype wire

// ---- ctsm_top.sv ----
/*
  Contactless tag protocol state machine: frame checking, wait states,
  two-level anticollision, tag and data memory states, reply serialiser.
  Assumes a byte-level receive front end, external CRC check, external
  password compare and an external responder that streams reply bytes.
*/
`timescale 1ns/10ps
`default_nettype none
module ctsm_top #(
  parameter int P_PAGES = 256,
  parameter logic [7:0] P_READ_CMD = 8'h30,
  parameter logic [7:0] P_FAST_CMD = 8'h3a,
  parameter logic [7:0] P_WRITE_CMD = 8'ha2,
  parameter logic [7:0] P_HLTA_CMD = 8'h50,
  parameter logic [7:0] P_TAG_PWD_CMD = 8'h1b,
  parameter logic [7:0] P_DM_PWD_CMD = 8'hb1,
  parameter logic [7:0] P_DM_RD_CMD = 8'hb2,
  parameter logic [7:0] P_DM_WR_CMD = 8'hb3,
  parameter logic [7:0] P_LOCK_GET_CMD = 8'hb4,
  parameter logic [7:0] P_LOCK_SET_CMD = 8'hb5
) (
  input wire logic I_MCLK,
  input wire logic I_NRST,
  input wire ctsm_pkg::ctsm_rx_t I_RX,
  input wire logic I_BIT_TICK,
  input wire ctsm_pkg::ctsm_tx_t I_TX,
  input wire ctsm_pkg::ctsm_pwd_t I_PWD,
  input wire logic [8*ctsm_pkg::UID_BYTES-1:0] I_UID,
  input wire logic [7:0] I_AUTH0,
  input wire logic [P_PAGES-1:0] I_DM_RD_LOCK,
  input wire logic [P_PAGES-1:0] I_DM_WR_LOCK,
  input wire logic [ctsm_pkg::BUF_AW-1:0] I_BUF_RADDR,
  output logic [7:0] O_BUF_RDATA,
  output var ctsm_pkg::ctsm_resp_t O_RESP,
  output var ctsm_pkg::ctsm_state_t O_STATE,
  output logic O_HALT_WAIT,
  output logic O_TX_RDY,
  output logic O_TX_BIT,
  output logic O_TX_EN,
  output logic O_TX_END
);
  import ctsm_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ctsm_state_t st;
    logic halt_wait;
    logic pwd_wait;
    logic pwd_dm;
    logic rx_in;
    logic rx_err;
    logic rx_short;
    logic [BUF_AW-1:0] rx_cnt;
    logic [BIT_CW-1:0] rx_bits;
    logic [HDR_BYTES-1:0][7:0] hdr;
    ctsm_resp_t resp;
    logic tx_full;
    logic tx_start;
    logic tx_last;
    logic tx_in;
    logic [BYTE_BITS-1:0] tx_sh;
    logic [LEFT_W-1:0] tx_left;
    logic [BIT_CW-1:0] tx_bits;
    logic tx_rdy;
    logic tx_bit;
    logic tx_en;
    logic tx_end;
  } ctsm_regs_t;

  ctsm_regs_t q;
  ctsm_regs_t d;
  logic mem_we;
  logic [BUF_AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic eval;
  logic frame_ok;
  logic long_ok;
  logic is_reqa;
  logic is_wupa;
  logic ac1;
  logic ac2;
  logic sel1;
  logic sel2;
  logic read0;
  logic hlta;
  logic tag_cmd;
  logic dm_rd;
  logic dm_wr;
  logic [7:0] b0;
  logic [7:0] b1;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  function automatic logic cmd_is(input logic [7:0] c);
    return long_ok && (b0 == c);
  endfunction

  // Anticollision frames carry no CRC, so they are checked on parity, length and their two code bytes alone
  assign b0 = q.hdr[0];
  assign b1 = q.hdr[1];
  assign eval = q.rx_in && I_RX.eof && !q.pwd_wait;
  assign frame_ok = !q.rx_err && (q.rx_cnt != '0);
  assign long_ok = frame_ok && !q.rx_short && I_RX.crc_ok;
  assign is_reqa = frame_ok && q.rx_short && (b0 == CMD_REQA);
  assign is_wupa = frame_ok && q.rx_short && (b0 == CMD_WUPA);
  assign ac1 = frame_ok && !q.rx_short && (q.rx_cnt == BUF_AW'(ANTICOL_BYTES)) && (b0 == CMD_CL1) &&
               (b1 == NVB_ANTICOL);
  assign ac2 = frame_ok && !q.rx_short && (q.rx_cnt == BUF_AW'(ANTICOL_BYTES)) && (b0 == CMD_CL2) &&
               (b1 == NVB_ANTICOL);
  assign sel1 = cmd_is(CMD_CL1) && (q.rx_cnt == BUF_AW'(SELECT_BYTES)) && (b1 == NVB_SELECT) &&
                uid_match(q.hdr, I_UID, 1'b0);
  assign sel2 = cmd_is(CMD_CL2) && (q.rx_cnt == BUF_AW'(SELECT_BYTES)) && (b1 == NVB_SELECT) &&
                uid_match(q.hdr, I_UID, 1'b1);
  assign read0 = cmd_is(P_READ_CMD) && (b1 == BLOCK_ZERO);
  assign hlta = cmd_is(P_HLTA_CMD) && (b1 == HLTA_ARG);
  assign tag_cmd = cmd_is(P_READ_CMD) || cmd_is(P_FAST_CMD) || cmd_is(P_WRITE_CMD);
  assign dm_rd = cmd_is(P_DM_RD_CMD);
  assign dm_wr = cmd_is(P_DM_WR_CMD);

  // Reply request carrying both address arguments for the responder
  function automatic ctsm_resp_t mk_resp(input ctsm_kind_t k);
    ctsm_resp_t r;
    r.req = 1'b1;
    r.kind = k;
    r.arg = b1;
    r.arg2 = q.hdr[HDR_ARG2_POS];
    return r;
  endfunction

  // Data memory access checked against the lock bit of its 64 byte region
  function automatic ctsm_kind_t dm_kind();
    if (dm_rd)
      return I_DM_RD_LOCK[b1] ? K_NAK : K_DM_READ;
    return I_DM_WR_LOCK[b1] ? K_NAK : K_DM_WRITE;
  endfunction

  // Protected tag blocks answer NAK until the tag password is verified
  function automatic ctsm_kind_t tag_kind(input logic authed);
    if (!authed && (b1 >= I_AUTH0))
      return K_NAK;
    if (cmd_is(P_FAST_CMD))
      return K_TAG_FAST;
    return cmd_is(P_WRITE_CMD) ? K_TAG_WRITE : K_TAG_READ;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    int nb;
    int tbits;
    ctsm_state_t fall;
    nb = BYTE_BITS;
    tbits = 0;
    d = q;
    d.resp.req = 1'b0;
    d.tx_en = 1'b0;
    d.tx_end = 1'b0;
    mem_we = 1'b0;
    mem_waddr = q.rx_cnt;
    mem_wdata = I_RX.data;
    fall = q.halt_wait ? ST_HALT : ST_IDLE;

    // Receive: count bits, check parity, store bytes in arrival order
    if (I_RX.sof && !q.pwd_wait)
    begin
      d.rx_in = 1'b1;
      d.rx_err = 1'b0;
      d.rx_short = 1'b0;
      d.rx_cnt = '0;
      d.rx_bits = BIT_CW'(START_BITS);
    end
    else if (I_RX.vld && q.rx_in)
    begin
      nb = I_RX.short_frame ? SHORT_BITS : BYTE_BITS;
      if ((int'(q.rx_bits) + nb > RX_MAX_BITS) || (I_RX.short_frame && (q.rx_cnt != '0)))
      begin
        d.rx_err = 1'b1;
      end
      else
      begin
        d.rx_bits = q.rx_bits + BIT_CW'(nb);
        d.rx_cnt = q.rx_cnt + 1'b1;
        d.rx_short = I_RX.short_frame;
        mem_we = 1'b1;
        if (!I_RX.short_frame && (I_RX.par != odd_par(I_RX.data)))
          d.rx_err = 1'b1;
        if (int'(q.rx_cnt) < HDR_BYTES)
          d.hdr[q.rx_cnt] = I_RX.data;
      end
    end

    // Password compare result from the outside
    if (q.pwd_wait && I_PWD.done)
    begin
      d.pwd_wait = 1'b0;
      if (I_PWD.ok)
      begin
        d.st = q.pwd_dm ? ST_DM_AUTH : ST_TAG_AUTH;
        d.resp = mk_resp(q.pwd_dm ? K_DM_ACK : K_TAG_PACK);
      end
      else
      begin
        d.resp = mk_resp(K_NAK);
      end
    end

    // End of frame: protocol transitions; error frames get no reply
    if (eval)
    begin
      d.rx_in = 1'b0;
      unique case (q.st)
        ST_IDLE, ST_HALT:
        begin
          if (is_wupa || (is_reqa && (q.st == ST_IDLE)))
          begin
            d.st = ST_READY1;
            d.resp = mk_resp(K_ATQA);
          end
        end
        ST_READY1:
        begin
          if (ac1)
            d.resp = mk_resp(K_UID_CL1);
          else if (sel1)
          begin
            d.st = ST_READY2;
            d.resp = mk_resp(K_SAK_CL1);
          end
          else if (read0)
          begin
            d.st = ST_TAG_ACT;
            d.resp = mk_resp(K_TAG_READ);
          end
          else
            d.st = fall;
        end
        ST_READY2:
        begin
          if (ac2)
            d.resp = mk_resp(K_UID_CL2);
          else if (sel2)
          begin
            d.st = ST_TAG_ACT;
            d.resp = mk_resp(K_SAK_CL2);
          end
          else if (read0)
          begin
            d.st = ST_TAG_ACT;
            d.resp = mk_resp(K_TAG_READ);
          end
          else
            d.st = fall;
        end
        ST_TAG_ACT, ST_TAG_AUTH:
        begin
          if (hlta)
          begin
            d.st = ST_HALT;
            d.halt_wait = 1'b1;
          end
          else if (tag_cmd)
            d.resp = mk_resp(tag_kind(q.st == ST_TAG_AUTH));
          else if (cmd_is(P_TAG_PWD_CMD))
          begin
            d.pwd_wait = 1'b1;
            d.pwd_dm = 1'b0;
            d.resp = mk_resp(K_PWD_TAG);
          end
          else if ((q.st == ST_TAG_ACT) && (dm_rd || dm_wr))
          begin
            d.st = ST_DM_ACT;
            d.resp = mk_resp(dm_kind());
          end
          else if ((q.st == ST_TAG_ACT) && cmd_is(P_DM_PWD_CMD))
          begin
            d.st = ST_DM_ACT;
            d.pwd_wait = 1'b1;
            d.pwd_dm = 1'b1;
            d.resp = mk_resp(K_PWD_DM);
          end
          else
            d.st = fall;
        end
        ST_DM_ACT, ST_DM_AUTH:
        begin
          if (dm_rd || dm_wr)
            d.resp = mk_resp(dm_kind());
          else if ((q.st == ST_DM_ACT) && cmd_is(P_DM_PWD_CMD))
          begin
            d.pwd_wait = 1'b1;
            d.pwd_dm = 1'b1;
            d.resp = mk_resp(K_PWD_DM);
          end
          else if (cmd_is(P_LOCK_GET_CMD))
            d.resp = mk_resp(K_LOCK_GET);
          else if (cmd_is(P_LOCK_SET_CMD))
            d.resp = mk_resp((q.st == ST_DM_AUTH) ? K_LOCK_SET : K_NAK);
          else
          begin
            d.st = ST_HALT;
            d.halt_wait = 1'b1;
          end
        end
      endcase
    end

    // Transmit: accept a byte, or shift one bit out per tick
    if (q.tx_rdy && I_TX.vld)
    begin
      tbits = int'(q.tx_bits) + (I_TX.nib ? NIB_BITS : BYTE_BITS) + (q.tx_in ? 0 : START_BITS);
      if (tbits > TX_MAX_BITS)
      begin
        d.tx_in = 1'b0;
        d.tx_bits = '0;
        d.tx_end = q.tx_in;
      end
      else
      begin
        d.tx_full = 1'b1;
        d.tx_start = !q.tx_in;
        d.tx_in = 1'b1;
        d.tx_last = I_TX.last;
        d.tx_bits = BIT_CW'(tbits);
        d.tx_sh = I_TX.nib ? {{(BYTE_BITS-NIB_BITS){1'b0}}, I_TX.data[NIB_BITS-1:0]}
                           : {odd_par(I_TX.data), I_TX.data};
        d.tx_left = I_TX.nib ? LEFT_W'(NIB_BITS) : LEFT_W'(BYTE_BITS);
      end
    end
    else if (q.tx_full && I_BIT_TICK)
    begin
      d.tx_en = 1'b1;
      if (q.tx_start)
      begin
        d.tx_bit = START_LEVEL;
        d.tx_start = 1'b0;
      end
      else
      begin
        d.tx_bit = q.tx_sh[0];
        d.tx_sh = q.tx_sh >> 1;
        d.tx_left = q.tx_left - 1'b1;
        if (q.tx_left == ONE_LEFT)
        begin
          d.tx_full = 1'b0;
          if (q.tx_last)
          begin
            d.tx_in = 1'b0;
            d.tx_bits = '0;
            d.tx_end = 1'b1;
          end
        end
      end
    end
    d.tx_rdy = !d.tx_full;
  end

  // Whole state in one register
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
      q <= '0;
    else
      q <= d;
  end

  // Frame bytes kept for the responder
  ctsm_frame_mem #(.WIDTH(8), .DEPTH(RX_MAX_BYTES), .AW(BUF_AW)) u_mem (
    .i_clk(I_MCLK),
    .i_nrst(I_NRST),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(I_BUF_RADDR),
    .o_rdata(O_BUF_RDATA)
  );

  // Outputs straight from the state register
  assign O_RESP = q.resp;
  assign O_STATE = q.st;
  assign O_HALT_WAIT = q.halt_wait;
  assign O_TX_RDY = q.tx_rdy;
  assign O_TX_BIT = q.tx_bit;
  assign O_TX_EN = q.tx_en;
  assign O_TX_END = q.tx_end;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  idle_wait_a: assert property (eval && (q.st == ST_IDLE) && !(is_reqa || is_wupa) |=>
    (O_STATE == ST_IDLE) && !O_RESP.req) else $error("idle left on a bad frame");
  halt_exit_a: assert property (eval && (q.st == ST_HALT) |=>
    ((O_STATE == ST_READY1) == $past(is_wupa)) && (O_STATE inside {ST_HALT, ST_READY1}))
    else $error("halt exit not tied to WUPA");
  hlta_halt_a: assert property (eval && (q.st inside {ST_TAG_ACT, ST_TAG_AUTH}) && hlta |=>
    (O_STATE == ST_HALT) && O_HALT_WAIT && !O_RESP.req) else $error("HLTA did not halt");
  sel1_ready2_a: assert property (eval && (q.st == ST_READY1) && sel1 |=>
    (O_STATE == ST_READY2) && O_RESP.req && (O_RESP.kind == K_SAK_CL1)) else $error("CL1 select failed");
  read0_skip_a: assert property (eval && (q.st inside {ST_READY1, ST_READY2}) && read0 |=>
    (O_STATE == ST_TAG_ACT) && (O_RESP.kind == K_TAG_READ)) else $error("read 0 did not activate");
  ready_fall_a: assert property (eval && (q.st == ST_READY1) && !(ac1 || sel1 || read0) |=>
    ((O_STATE == ST_HALT) == $past(q.halt_wait)) && (O_STATE inside {ST_IDLE, ST_HALT}) && !O_RESP.req)
    else $error("ready error fallback wrong");
  sel2_sak_a: assert property (eval && (q.st == ST_READY2) && sel2 |=>
    (O_STATE == ST_TAG_ACT) && (O_RESP.kind == K_SAK_CL2)) else $error("CL2 select gave no SAK");
  dm_error_a: assert property (eval && (q.st inside {ST_DM_ACT, ST_DM_AUTH}) && !long_ok |=>
    (O_STATE == ST_HALT) && O_HALT_WAIT) else $error("data memory error did not halt");
  dm_lock_a: assert property (eval && (q.st == ST_DM_ACT) && dm_rd && I_DM_RD_LOCK[b1] |=>
    O_RESP.req && (O_RESP.kind == K_NAK)) else $error("locked region not refused");
  tx_start_a: assert property (q.tx_full && q.tx_start && I_BIT_TICK |=>
    O_TX_EN && (O_TX_BIT == START_LEVEL)) else $error("no start bit");
  tx_budget_a: assert property (q.tx_bits <= BIT_CW'(TX_MAX_BITS)) else $error("reply over budget");
  rx_budget_a: assert property (q.rx_bits <= BIT_CW'(RX_MAX_BITS)) else $error("frame over budget");

  sel2_c: cover property (eval && (q.st == ST_READY2) && sel2);
  read0_c: cover property (eval && (q.st == ST_READY1) && read0);
  pwd_ok_c: cover property (q.pwd_wait && I_PWD.done && I_PWD.ok);
  tx_end_c: cover property (q.tx_end);

endmodule
`default_nettype wire

// ---- tb_contactless_tag_state_machine.sv ----
/*
  Self-checking bench for the tag protocol state machine.
  Assumes the reader model is compiled before this file.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_contactless_tag_state_machine;
  import ctsm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic tick = 1'b0;
  ctsm_rx_t rx;
  ctsm_tx_t tx = '0;
  ctsm_pwd_t pwd = '0;
  logic [55:0] uid = '0;
  logic [255:0] rdl = '0;
  ctsm_resp_t resp;
  ctsm_state_t st;
  logic hw, tbit, ten, tend, trdy;
  logic [7:0] brd;
  int failures = 0;
  int num_checks = 0;
  int ends = 0;
  logic [7:0] q[$];
  logic tq[$];
  always #5 clk = ~clk;
  ctsm_reader rdr (.i_clk(clk), .o_rx(rx));
  ctsm_top dut (.I_MCLK(clk), .I_NRST(nrst), .I_RX(rx), .I_BIT_TICK(tick), .I_TX(tx), .I_PWD(pwd),
    .I_UID(uid), .I_AUTH0(8'h10), .I_DM_RD_LOCK(rdl), .I_DM_WR_LOCK(rdl), .I_BUF_RADDR(7'h01),
    .O_BUF_RDATA(brd), .O_RESP(resp), .O_STATE(st), .O_HALT_WAIT(hw), .O_TX_RDY(trdy), .O_TX_BIT(tbit),
    .O_TX_EN(ten), .O_TX_END(tend));
  // ------------------------------------------------
  // Checking helpers
  // ------------------------------------------------
  task automatic check(input string n, input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watcher: an answer with no note left is checked against 8'hff, a kind never used
  always @(negedge clk)
  begin
    if (resp.req === 1'b1)
      check("resp", {resp.kind, st}, (q.size() > 0) ? q.pop_front() : 8'hff);
    if (ten === 1'b1)
      check("tx_bit", tbit, (tq.size() > 0) ? tq.pop_front() : 1'bx);
    if (tend === 1'b1)
      ends++;
  end
  // Frame with random byte spacing; error frames must stay silent
  task automatic frame(input logic [7:0] b[$], input logic sh, input logic rq, input ctsm_kind_t k,
                       input ctsm_state_t s);
    if (rq)
      q.push_back({k, s});
    rdr.send(b, sh, $urandom_range(2));
    repeat (2) @(negedge clk);
    check("state", st, s);
    check("pending", q.size(), 0);
    if (b.size() > 1)
      check("buf", brd, b[1]);
  endtask
  task automatic pw(input logic ok, input ctsm_kind_t k, input ctsm_state_t s);
    q.push_back({k, s});
    @(negedge clk);
    pwd = {1'b1, ok};
    @(negedge clk);
    pwd = '0;
    repeat (2) @(negedge clk);
    check("pwd_state", st, s);
  endtask
  task automatic wake();
    frame({CMD_WUPA}, 1, 1, K_ATQA, ST_READY1);
    frame({8'h30, BLOCK_ZERO, 8'hc3, 8'h3c}, 0, 1, K_TAG_READ, ST_TAG_ACT);
  endtask
  // One reply byte: start bit, data low bit first, odd parity
  task automatic tx_byte(input logic [7:0] d);
    tq.push_back(1'b1);
    for (int i = 0; i < 8; i++)
      tq.push_back(d[i]);
    tq.push_back(~^d);
    @(negedge clk);
    tx = {1'b1, 1'b0, 1'b1, d};
    @(negedge clk);
    tx = '0;
    check("tx_busy", trdy, 0);
    repeat (10)
    begin
      @(negedge clk);
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
    end
    repeat (3) @(negedge clk);
    check("tx_left", tq.size(), 0);
    check("tx_end", ends, 1);
    check("tx_rdy", trdy, 1);
  endtask
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end
  // Main sequence
  initial
  begin
    void'($urandom(28));
    uid = 56'({$urandom(), $urandom()});
    rdl[5] = 1'b1;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    check("reset", st, ST_IDLE);
    frame({8'h30, 8'h00, 8'hc3, 8'h3c}, 0, 0, K_NAK, ST_IDLE);
    frame({CMD_REQA}, 1, 1, K_ATQA, ST_READY1);
    frame({CMD_CL1, NVB_ANTICOL}, 0, 1, K_UID_CL1, ST_READY1);
    frame({CMD_CL1, NVB_SELECT, CASCADE_TAG, uid[7:0], uid[15:8], uid[23:16], 8'h00, 8'hc3, 8'h3c},
          0, 1, K_SAK_CL1, ST_READY2);
    frame({CMD_CL2, NVB_ANTICOL}, 0, 1, K_UID_CL2, ST_READY2);
    frame({CMD_CL2, NVB_SELECT, uid[31:24], uid[39:32], uid[47:40], uid[55:48], 8'h00, 8'hc3, 8'h3c},
          0, 1, K_SAK_CL2, ST_TAG_ACT);
    frame({8'h30, 8'h10, 8'hc3, 8'h3c}, 0, 1, K_NAK, ST_TAG_ACT);
    frame({8'h50, HLTA_ARG, 8'hc3, 8'h3c}, 0, 0, K_NAK, ST_HALT);
    check("halt_wait", hw, 1);
    frame({CMD_REQA}, 1, 0, K_NAK, ST_HALT);
    frame({CMD_WUPA}, 1, 1, K_ATQA, ST_READY1);
    frame({8'h44}, 0, 0, K_NAK, ST_HALT);
    wake();
    for (int i = 0; i < 2; i++)
    begin
      frame({8'h1b, uid[7:0], uid[15:8], 8'h11, 8'h22, 8'hc3, 8'h3c}, 0, 1, K_PWD_TAG, ST_TAG_ACT);
      pw(i[0], i[0] ? K_TAG_PACK : K_NAK, i[0] ? ST_TAG_AUTH : ST_TAG_ACT);
    end
    frame({8'h30, 8'h10, 8'hc3, 8'h3c}, 0, 1, K_TAG_READ, ST_TAG_AUTH);
    frame({8'h3a, 8'h10, 8'h12, 8'hc3, 8'h3c}, 0, 1, K_TAG_FAST, ST_TAG_AUTH);
    frame({8'ha2, 8'h11, 8'h01, 8'h02, 8'h03, 8'h04, 8'hc3, 8'h3c}, 0, 1, K_TAG_WRITE, ST_TAG_AUTH);
    frame({8'h44}, 0, 0, K_NAK, ST_HALT);
    wake();
    frame({8'hb2, 8'h06, 8'hc3, 8'h3c}, 0, 1, K_DM_READ, ST_DM_ACT);
    frame({8'hb2, 8'h05, 8'hc3, 8'h3c}, 0, 1, K_NAK, ST_DM_ACT);
    frame({8'hb3, 8'h05, 8'hc3, 8'h3c}, 0, 1, K_NAK, ST_DM_ACT);
    frame({8'hb3, 8'h07, 8'hc3, 8'h3c}, 0, 1, K_DM_WRITE, ST_DM_ACT);
    frame({8'hb4, 8'h00, 8'hc3, 8'h3c}, 0, 1, K_LOCK_GET, ST_DM_ACT);
    frame({8'hb5, 8'h00, 8'h01, 8'hc3, 8'h3c}, 0, 1, K_NAK, ST_DM_ACT);
    frame({8'hb1, uid[7:0], 8'h33, 8'h11, 8'h22, 8'hc3, 8'h3c}, 0, 1, K_PWD_DM, ST_DM_ACT);
    pw(1'b1, K_DM_ACK, ST_DM_AUTH);
    frame({8'hb5, 8'h00, 8'h01, 8'hc3, 8'h3c}, 0, 1, K_LOCK_SET, ST_DM_AUTH);
    frame({8'h44}, 0, 0, K_NAK, ST_HALT);
    tx_byte(8'($urandom()));
    results();
  end
endmodule
`default_nettype wire
